// [tcs_top.sv]
// temperature conversion scheduler: axi4-lite registers, conversion timing, fault queue
// assumes a 20 MHz aclk and a free-running converter clock on adc_clk
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module tcs_top #(
    parameter int unsigned CONV_CYC = tcs_pkg::CONV_CYCLES,
    parameter int unsigned DLY1_CYC = tcs_pkg::DLY1_CYCLES,
    parameter int unsigned DLY2_CYC = tcs_pkg::DLY2_CYCLES,
    parameter int unsigned DLY3_CYC = tcs_pkg::DLY3_CYCLES
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic        awvalid,
    output var  logic        awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    // axi4-lite write data
    input  wire logic        wvalid,
    output var  logic        wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // axi4-lite write response
    output var  logic        bvalid,
    input  wire logic        bready,
    output var  logic [1:0]  bresp,
    // axi4-lite read address
    input  wire logic        arvalid,
    output var  logic        arready,
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    // axi4-lite read data
    output var  logic        rvalid,
    input  wire logic        rready,
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    // converter link
    input  wire logic        adc_clk,
    input  wire logic        adc_valid,
    input  wire logic [11:0] adc_data,
    output var  logic        adc_power_en,
    // limit alarm
    output var  logic        alarm_out
);

    tcs_pkg::tcs_top_t q;
    tcs_pkg::tcs_top_t n;
    logic              link_tgl;
    logic [11:0]       link_data;

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[1]) r[15:8] = wd[15:8];
        if (be[0]) r[7:0] = wd[7:0];
        return r;
    endfunction : merge16

    function automatic logic [2:0] depth_need(input logic [1:0] code);
        logic [2:0] r;
        unique case (code)
            2'b00: r = 3'h1;
            2'b01: r = 3'h2;
            2'b10: r = 3'h4;
            2'b11: r = 3'h6;
        endcase
        return r;
    endfunction : depth_need

    function automatic logic [23:0] dly_cyc(input logic [1:0] code);
        logic [23:0] r;
        unique case (code)
            2'b00: r = 24'h00_0001;
            2'b01: r = 24'(DLY1_CYC);
            2'b10: r = 24'(DLY2_CYC);
            2'b11: r = 24'(DLY3_CYC);
        endcase
        return r;
    endfunction : dly_cyc

    // index decode of a byte address, bit 6 flags an unmapped one
    function automatic logic [6:0] reg_idx(input logic [7:0] a);
        logic [6:0] r;
        r = {1'b0, a[7:2]};
        if (a[7:2] > tcs_pkg::IDX_STAT) r[6] = 1'b1;
        return r;
    endfunction : reg_idx

    // converter clock domain
    tcs_link u_link (
        .adc_clk      (adc_clk),
        .aresetn      (aresetn),
        .conv_run     (q.state == tcs_pkg::ST_CONV),
        .adc_valid    (adc_valid),
        .adc_data     (adc_data),
        .adc_power_en (adc_power_en),
        .sample_tgl   (link_tgl),
        .sample_data  (link_data)
    );

    // bus, registers and scheduler next state
    always_comb begin
        logic        do_wr;
        logic        pd_rise;
        logic        trig_go;
        logic        gcall;
        logic        conv_end;
        logic        fault;
        logic [15:0] word;
        logic [15:0] cfg_word;
        logic [6:0]  widx;
        logic [6:0]  ridx;
        do_wr    = 1'b0;
        pd_rise  = 1'b0;
        trig_go  = 1'b0;
        gcall    = 1'b0;
        conv_end = 1'b0;
        fault    = 1'b0;
        word     = 16'h0000;
        n        = q;
        cfg_word = {1'b0, q.rate_sel, q.fault_queue_depth, q.pol, q.tm, q.power_down_bit,
                    tcs_pkg::CFG_LOW_BYTE};
        widx     = reg_idx(q.aw_addr);
        ridx     = reg_idx(araddr);

        // read channel
        if (q.rvalid && rready) n.rvalid = 1'b0;
        if (arvalid && q.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = tcs_pkg::RESP_OKAY;
            n.rdata  = 32'h0000_0000;
            if (ridx[6]) begin
                n.rresp = tcs_pkg::RESP_SLVERR;
            end else begin
                unique case (ridx[5:0])
                    tcs_pkg::IDX_TEMP:  n.rdata[15:0] = {q.temp, 4'h0};
                    tcs_pkg::IDX_CFG:   n.rdata[15:0] = cfg_word;
                    tcs_pkg::IDX_TLOW:  n.rdata[15:0] = {q.tlow, 4'h0};
                    tcs_pkg::IDX_THIGH: n.rdata[15:0] = {q.thigh, 4'h0};
                    tcs_pkg::IDX_STAT:  n.rdata[5:0]  = {q.fcnt, q.alarm, q.state};
                    default:            n.rdata = 32'h0000_0000;
                endcase
                if (q.tm) n.alarm = 1'b0;        // interrupt mode clears on any mapped read
            end
        end
        n.arready = ~n.rvalid;

        // write channels, address and data in either order
        if (q.bvalid && bready) n.bvalid = 1'b0;
        if (awvalid && q.awready) begin
            n.aw_have = 1'b1;
            n.aw_addr = awaddr;
        end
        if (wvalid && q.wready) begin
            n.w_have = 1'b1;
            n.w_data = wdata;
            n.w_strb = wstrb;
        end
        do_wr = q.aw_have && q.w_have && !q.bvalid;
        if (do_wr) begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = widx[6] ? tcs_pkg::RESP_SLVERR : tcs_pkg::RESP_OKAY;
            if (!widx[6]) begin
                unique case (widx[5:0])
                    tcs_pkg::IDX_CFG: begin
                        word = merge16(cfg_word, q.w_data, q.w_strb);
                        n.rate_sel          = word[tcs_pkg::CFG_RATE_HI:tcs_pkg::CFG_RATE_LO];
                        n.fault_queue_depth = word[tcs_pkg::CFG_DEPTH_HI:tcs_pkg::CFG_DEPTH_LO];
                        n.pol               = word[tcs_pkg::CFG_POL];
                        n.tm                = word[tcs_pkg::CFG_TM];
                        n.power_down_bit    = word[tcs_pkg::CFG_PDOWN];
                        pd_rise = word[tcs_pkg::CFG_PDOWN] && !q.power_down_bit;
                        trig_go = word[tcs_pkg::CFG_ONESHOT] && word[tcs_pkg::CFG_PDOWN]
                                  && (q.state == tcs_pkg::ST_SHUT);
                    end
                    tcs_pkg::IDX_TLOW: begin
                        word   = merge16({q.tlow, 4'h0}, q.w_data, q.w_strb);
                        n.tlow = word[15:4];
                    end
                    tcs_pkg::IDX_THIGH: begin
                        word    = merge16({q.thigh, 4'h0}, q.w_data, q.w_strb);
                        n.thigh = word[15:4];
                    end
                    tcs_pkg::IDX_STAT: gcall = q.w_strb[0] && q.w_data[tcs_pkg::STAT_GCALL];
                    default:           gcall = 1'b0;       // temperature is read only
                endcase
            end
        end
        n.awready = ~n.aw_have;
        n.wready  = ~n.w_have;

        // sample crossing: toggle through two flops, data taken on its edge
        n.tgl_s1 = link_tgl;
        n.tgl_s2 = q.tgl_s1;
        n.tgl_s3 = q.tgl_s2;
        if (q.tgl_s2 != q.tgl_s3) n.sample = link_data;

        // conversion scheduler
        n.cnt = q.cnt + 24'h00_0001;
        unique case (q.state)
            tcs_pkg::ST_CONV: begin
                if (q.cnt == 24'(CONV_CYC - 1)) begin
                    conv_end = 1'b1;
                    n.cnt    = 24'h00_0000;
                    if (n.power_down_bit) begin
                        n.state = tcs_pkg::ST_SHUT;
                    end else if (q.rate_sel == 2'b00) begin
                        n.state = tcs_pkg::ST_CONV;
                    end else begin
                        n.state = tcs_pkg::ST_DELAY;
                    end
                end
            end
            tcs_pkg::ST_DELAY: begin
                if (n.power_down_bit) begin
                    n.state = tcs_pkg::ST_SHUT;
                    n.cnt   = 24'h00_0000;
                end else if (q.cnt >= dly_cyc(q.rate_sel) - 24'h00_0001) begin
                    n.state = tcs_pkg::ST_CONV;
                    n.cnt   = 24'h00_0000;
                end
            end
            tcs_pkg::ST_SHUT: begin
                n.cnt = 24'h00_0000;
                if (!n.power_down_bit || trig_go) n.state = tcs_pkg::ST_CONV;
            end
            default: begin
                n.state = tcs_pkg::ST_CONV;
                n.cnt   = 24'h00_0000;
            end
        endcase

        if (conv_end) begin
            n.temp = q.sample;
            fault  = $signed(q.sample) > $signed(q.thigh);
            if (fault) begin
                if (q.fcnt < depth_need(q.fault_queue_depth)) n.fcnt = q.fcnt + 3'h1;
                if (q.fcnt + 3'h1 >= depth_need(q.fault_queue_depth)) n.alarm = 1'b1;
            end else begin
                n.fcnt = 3'h0;
                if (!q.tm && ($signed(q.sample) < $signed(q.tlow))) n.alarm = 1'b0;
            end
        end

        if (pd_rise) begin
            n.fcnt  = 3'h0;
            n.alarm = 1'b0;
        end

        if (gcall) begin
            n.rate_sel          = 2'b00;
            n.fault_queue_depth = 2'b00;
            n.pol               = 1'b0;
            n.tm                = 1'b0;
            n.power_down_bit    = 1'b0;
            n.tlow              = tcs_pkg::TLOW_RST;
            n.thigh             = tcs_pkg::THIGH_RST;
            n.temp              = tcs_pkg::TEMP_RST;
            n.state             = tcs_pkg::ST_CONV;
            n.cnt               = 24'h00_0000;
            n.fcnt              = 3'h0;
            n.alarm             = 1'b0;
        end

        // polarity: low active unless pol set
        n.alarm_out = n.pol ? n.alarm : ~n.alarm;
    end

    // register the state; reset starts a conversion at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q                   <= '0;
            q.awready           <= 1'b1;
            q.wready            <= 1'b1;
            q.arready           <= 1'b1;
            q.tlow              <= tcs_pkg::TLOW_RST;
            q.thigh             <= tcs_pkg::THIGH_RST;
            q.temp              <= tcs_pkg::TEMP_RST;
            q.state             <= tcs_pkg::ST_CONV;
            q.alarm_out         <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // outputs straight from flops
    assign awready   = q.awready;
    assign wready    = q.wready;
    assign bvalid    = q.bvalid;
    assign bresp     = q.bresp;
    assign arready   = q.arready;
    assign rvalid    = q.rvalid;
    assign rdata     = q.rdata;
    assign rresp     = q.rresp;
    assign alarm_out = q.alarm_out;

endmodule : tcs_top
`default_nettype wire

// [tcs_pkg.sv]
// constants, register layout and state types of the temperature conversion scheduler
// assumes a 20 MHz bus clock and a 32-bit axi4-lite register bus
package tcs_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ         = 20000000;
    localparam int unsigned CLK_MHZ        = 20;
    localparam int unsigned CONV_TIME_US   = 27000;            // one conversion, typical
    localparam int unsigned RATE0_HZ       = 37;               // back to back conversions
    localparam int unsigned RATE1_HZ       = 18;
    localparam int unsigned RATE2_HZ       = 9;
    localparam int unsigned RATE3_HZ       = 4;
    localparam int unsigned CONV_CYCLES    = CONV_TIME_US * CLK_MHZ;
    localparam int unsigned DLY1_CYCLES    = CLK_HZ / RATE1_HZ - CONV_CYCLES;
    localparam int unsigned DLY2_CYCLES    = CLK_HZ / RATE2_HZ - CONV_CYCLES;
    localparam int unsigned DLY3_CYCLES    = CLK_HZ / RATE3_HZ - CONV_CYCLES;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_TEMP        = 6'h00;
    localparam logic [5:0] IDX_CFG         = 6'h01;
    localparam logic [5:0] IDX_TLOW        = 6'h02;
    localparam logic [5:0] IDX_THIGH       = 6'h03;
    localparam logic [5:0] IDX_STAT        = 6'h04;

    // configuration field positions
    localparam int unsigned CFG_ONESHOT    = 15;
    localparam int unsigned CFG_RATE_HI    = 14;
    localparam int unsigned CFG_RATE_LO    = 13;
    localparam int unsigned CFG_DEPTH_HI   = 12;
    localparam int unsigned CFG_DEPTH_LO   = 11;
    localparam int unsigned CFG_POL        = 10;
    localparam int unsigned CFG_TM         = 9;
    localparam int unsigned CFG_PDOWN      = 8;
    localparam logic [7:0]  CFG_LOW_BYTE   = 8'hFF;            // reserved, reads all ones
    localparam int unsigned STAT_GCALL     = 0;                // write 1: general-call reset

    // values after reset
    localparam logic [11:0] TLOW_RST       = 12'h4B0;
    localparam logic [11:0] THIGH_RST      = 12'h500;
    localparam logic [11:0] TEMP_RST       = 12'h000;

    // axi responses
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;

    typedef enum logic [1:0] {
        ST_CONV  = 2'b00,
        ST_DELAY = 2'b01,
        ST_SHUT  = 2'b10
    } tcs_state_t;

    // bus clock domain state of the top module
    typedef struct packed {
        logic        aw_have;
        logic [7:0]  aw_addr;
        logic        w_have;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [1:0]  rate_sel;
        logic [1:0]  fault_queue_depth;
        logic        pol;
        logic        tm;
        logic        power_down_bit;
        logic [11:0] tlow;
        logic [11:0] thigh;
        logic [11:0] temp;
        tcs_state_t  state;
        logic [23:0] cnt;
        logic [2:0]  fcnt;
        logic        alarm;
        logic        alarm_out;
        logic        tgl_s1;
        logic        tgl_s2;
        logic        tgl_s3;
        logic [11:0] sample;
    } tcs_top_t;

    // converter clock domain state of the link module
    typedef struct packed {
        logic        rst_s1;
        logic        rst_s2;
        logic        en_s1;
        logic        en_s2;
        logic        adc_power_en;
        logic        tgl;
        logic [11:0] data;
    } tcs_link_t;

endpackage : tcs_pkg

// [tcs_link.sv]
// converter-side logic, clocked by the converter clock
// assumes the converter delivers at most one sample each fourth converter clock
`timescale 1ns/1ps
`default_nettype none
module tcs_link (
    // converter clock
    input  wire logic        adc_clk,
    // bus domain reset and run request
    input  wire logic        aresetn,
    input  wire logic        conv_run,
    // converter pins
    input  wire logic        adc_valid,
    input  wire logic [11:0] adc_data,
    output var  logic        adc_power_en,
    // sample towards the bus domain
    output var  logic        sample_tgl,
    output var  logic [11:0] sample_data
);

    tcs_pkg::tcs_link_t q;
    tcs_pkg::tcs_link_t n;

    // synchronise reset and run level, catch samples
    always_comb begin
        n        = q;
        n.rst_s1 = aresetn;
        n.rst_s2 = q.rst_s1;
        n.en_s1  = conv_run;
        n.en_s2  = q.en_s1;
        n.adc_power_en = q.en_s2;                // converter off in delay and shutdown
        if (q.adc_power_en && adc_valid) begin
            n.data = adc_data;                   // data settles before the toggle is seen
            n.tgl  = ~q.tgl;
        end
        if (!q.rst_s2) begin
            n.adc_power_en = 1'b0;
            n.tgl          = 1'b0;
            n.data         = tcs_pkg::TEMP_RST;
        end
    end

    // register the state
    always_ff @(posedge adc_clk) begin
        q <= n;
    end

    assign adc_power_en = q.adc_power_en;
    assign sample_tgl   = q.tgl;
    assign sample_data  = q.data;

endmodule : tcs_link
`default_nettype wire

// [tcs_adc_model.sv]
// converter model: hands samples to the link while powered
// assumes adc_power_en comes from the link and temp_val from the bench
`timescale 1ns/1ps
`default_nettype none
module tcs_adc_model (
    // converter clock and power
    input  wire logic        adc_clk,
    input  wire logic        adc_power_en,
    // value to report
    input  wire logic [11:0] temp_val,
    // sample pins
    output var  logic        adc_valid,
    output var  logic [11:0] adc_data
);
    logic [1:0] div_q = 2'd0;
    initial adc_valid = 1'b0;
    initial adc_data = 12'h000;
    // no samples unpowered
    // one sample each fourth clock; data toggles while off
    always @(posedge adc_clk) begin
        div_q <= adc_power_en ? div_q + 2'd1 : 2'd0;
        adc_valid <= adc_power_en && (div_q == 2'd3);
        adc_data <= adc_power_en ? temp_val : ~adc_data;
    end
endmodule : tcs_adc_model
`default_nettype wire

// [tcs_chk_sva.sv]
// checker: bus answers and converter power seen at tcs_top ports
// assumes aclk and adc_clk unrelated, bound to every tcs_top
`timescale 1ns/1ps
`default_nettype none
module tcs_chk #(
    parameter int unsigned CONV_CYC = 40,
    parameter int unsigned DLY1_CYC = 16,
    parameter int unsigned DLY2_CYC = 32,
    parameter int unsigned DLY3_CYC = 48
) (
    // bus side
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [7:0]  araddr,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    // converter and alarm
    input wire logic        adc_clk,
    input wire logic        adc_power_en,
    input wire logic        alarm_out
);
    localparam int ON_MIN = int'(CONV_CYC) * 50 / 64 - 4;
    logic [7:0] ar_q;
    int         on_q;
    // last read address
    always_ff @(posedge aclk) begin
        if (arvalid && arready) begin
            ar_q <= araddr;
        end
    end
    // powered span in converter clocks
    always_ff @(posedge adc_clk) begin
        on_q <= (adc_power_en && aresetn) ? on_q + 1 : 0;
    end
    AST_WR_RESP:
        assert property (@(posedge aclk) disable iff (!aresetn)
            awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
        else $error("write answer not two cycles after take");
    AST_B_ONCE:
        assert property (@(posedge aclk) disable iff (!aresetn) bvalid && bready |=> !bvalid)
        else $error("write answer repeated");
    AST_RD_RESP:
        assert property (@(posedge aclk) disable iff (!aresetn) arvalid && arready |=> rvalid)
        else $error("read answer late");
    AST_R_ONCE:
        assert property (@(posedge aclk) disable iff (!aresetn) rvalid && rready |=> !rvalid)
        else $error("read answer repeated");
    AST_AR_BLOCK:
        assert property (@(posedge aclk) disable iff (!aresetn) rvalid |-> !arready)
        else $error("read address taken while answer pending");
    AST_RST_OUT:
        assert property (@(posedge aclk) disable iff (!aresetn)
            $rose(aresetn) |-> !bvalid && !rvalid && alarm_out)
        else $error("outputs not idle after reset");
    AST_CFG_READ:
        assert property (@(posedge aclk) disable iff (!aresetn)
            rvalid && ar_q == 8'h04 |-> rdata[15] == 1'b0 && rdata[7:0] == 8'hFF)
        else $error("config trigger or low byte wrong");
    AST_UNMAPPED:
        assert property (@(posedge aclk) disable iff (!aresetn)
            rvalid && ar_q > 8'h13 |-> rresp == tcs_pkg::RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    AST_START:
        assert property (@(posedge adc_clk) disable iff (!aresetn)
            $rose(aresetn) |-> ##[1:12] adc_power_en)
        else $error("no conversion after reset");
    AST_CONV_FULL:
        assert property (@(posedge adc_clk) disable iff (!aresetn)
            $fell(adc_power_en) |-> on_q >= ON_MIN)
        else $error("conversion cut short");
    // main scenarios
    cover property (@(posedge aclk) disable iff (!aresetn) $fell(alarm_out));
    cover property (@(posedge aclk) disable iff (!aresetn) rvalid && rresp != 2'b00);
    cover property (@(posedge adc_clk) disable iff (!aresetn) $fell(adc_power_en));
endmodule : tcs_chk
bind tcs_top tcs_chk #(.CONV_CYC(CONV_CYC), .DLY1_CYC(DLY1_CYC), .DLY2_CYC(DLY2_CYC),
    .DLY3_CYC(DLY3_CYC)) u_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .adc_clk(adc_clk), .adc_power_en(adc_power_en),
    .alarm_out(alarm_out));
`default_nettype wire

// [tb.sv]
// testbench for tcs_top: register traffic, conversion timing, alarm
// assumes tcs_adc_model on the converter pins and tcs_chk bound in
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int CONV = 40, D1 = 16, D2 = 32, D3 = 48;
    int          dly [4] = '{0, D1, D2, D3};
    int          need [4] = '{1, 2, 4, 6};
    logic        aclk, aresetn, adc_clk, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [11:0] temp_val;
    wire         awready, wready, bvalid, arready, rvalid, adc_valid, adc_power_en, alarm_out;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [11:0] adc_data;
    int          bad_count, total_checks, lo, hi;
    bit          sh, sl;
    tcs_top #(.CONV_CYC(CONV), .DLY1_CYC(D1), .DLY2_CYC(D2), .DLY3_CYC(D3)) dut (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'b000), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'b000), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .adc_clk(adc_clk),
        .adc_valid(adc_valid), .adc_data(adc_data), .adc_power_en(adc_power_en),
        .alarm_out(alarm_out));
    tcs_adc_model u_adc (.adc_clk(adc_clk), .adc_power_en(adc_power_en),
        .temp_val(temp_val), .adc_valid(adc_valid), .adc_data(adc_data));
    // bus clock, then converter clock off phase
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    initial begin
        adc_clk = 1'b0;
        #7;
        forever #32 adc_clk = ~adc_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic near(input int got, input int exp);
        total_checks++;
        if (got > exp + 4 || got < exp - 4) begin
            bad_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : near
    // write: offer address and data together, drop each once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                      input logic [1:0] er);
        @(posedge aclk);
        {awvalid, wvalid, bready} <= 3'b111;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
        @(posedge aclk);
        {arvalid, rready} <= 2'b11;
        araddr <= a;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, ev);
        chk(32'(rresp), 32'(er));
    endtask : rd
    task automatic pw_wait(input logic lvl);
        while (adc_power_en !== lvl) @(posedge aclk);
    endtask : pw_wait
    // note whether power was seen high or low over n cycles
    task automatic span(input int n, output bit h, output bit l);
        h = 1'b0;
        l = 1'b0;
        repeat (n) begin
            @(posedge aclk);
            if (adc_power_en === 1'b1) h = 1'b1;
            if (adc_power_en !== 1'b1) l = 1'b1;
        end
    endtask : span
    // idle and powered lengths of one conversion cycle
    task automatic meas(output int l, output int h);
        l = 0;
        h = 0;
        pw_wait(1'b1);
        pw_wait(1'b0);
        while (adc_power_en === 1'b0) begin
            @(posedge aclk);
            l++;
        end
        pw_wait(1'b1);
        while (adc_power_en === 1'b1) begin
            @(posedge aclk);
            h++;
        end
    endtask : meas
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    // hang guard
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
        temp_val = 12'h123;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h00, 32'h0000_0000, 2'b00);
        rd(8'h04, 32'h0000_00FF, 2'b00);
        rd(8'h08, 32'h0000_4B00, 2'b00);
        rd(8'h0C, 32'h0000_5000, 2'b00);
        rd(8'h20, 32'h0000_0000, 2'b10);
        wr(8'h40, 32'h0000_FFFF, 4'h3, 2'b10);
        span(100, sh, sl);
        chk(32'(sl), 32'h0000_0000);
        rd(8'h00, 32'h0000_1230, 2'b00);
        temp_val <= 12'h234;
        repeat (100) @(posedge aclk);
        wr(8'h00, 32'h0000_FFFF, 4'h3, 2'b00);
        rd(8'h00, 32'h0000_2340, 2'b00);
        for (int r = 1; r < 4; r++) begin
            wr(8'h04, 32'(r) << 13, 4'h3, 2'b00);
            rd(8'h04, (32'(r) << 13) | 32'h0000_00FF, 2'b00);
            meas(lo, hi);
            near(lo, dly[r]);
            near(hi, CONV);
        end
        wr(8'h0C, 32'h0000_1230, 4'h3, 2'b00);
        wr(8'h0C, 32'h0000_AB00, 4'h2, 2'b00);
        rd(8'h0C, 32'h0000_AB30, 2'b00);
        wr(8'h08, 32'h0000_0000, 4'h3, 2'b00);
        for (int q = 0; q < 4; q++) begin
            wr(8'h0C, 32'h0000_7F00, 4'h3, 2'b00);
            wr(8'h04, 32'h0000_0100 | (32'(q) << 11), 4'h3, 2'b00);
            pw_wait(1'b0);
            wr(8'h0C, 32'h0000_0100, 4'h3, 2'b00);
            wr(8'h04, 32'(q) << 11, 4'h3, 2'b00);
            repeat (CONV * need[q] - 20) @(posedge aclk);
            chk(32'(alarm_out), 32'h0000_0001);
            repeat (40) @(posedge aclk);
            chk(32'(alarm_out), 32'h0000_0000);
        end
        wr(8'h04, 32'h0000_2000, 4'h3, 2'b00);
        pw_wait(1'b0);
        pw_wait(1'b1);
        repeat (10) @(posedge aclk);
        wr(8'h04, 32'h0000_2100, 4'h3, 2'b00);
        repeat (2) @(posedge aclk);
        chk(32'(adc_power_en), 32'h0000_0001);
        chk(32'(alarm_out), 32'h0000_0001);
        repeat (100) @(posedge aclk);
        chk(32'(adc_power_en), 32'h0000_0000);
        wr(8'h04, 32'h0000_2100, 4'h3, 2'b00);
        repeat (2) @(posedge aclk);
        chk(32'(alarm_out), 32'h0000_0000);
        wr(8'h04, 32'h0000_A100, 4'h3, 2'b00);
        pw_wait(1'b1);
        pw_wait(1'b0);
        span(100, sh, sl);
        chk(32'(sh), 32'h0000_0000);
        rd(8'h04, 32'h0000_21FF, 2'b00);
        wr(8'h04, 32'h0000_2700, 4'h3, 2'b00);
        chk(32'(alarm_out), 32'h0000_0001); // pol set shows the held alarm high
        rd(8'h04, 32'h0000_27FF, 2'b00);
        chk(32'(alarm_out), 32'h0000_0000); // interrupt mode read clears alarm
        wr(8'h10, 32'h0000_0001, 4'h1, 2'b00);
        repeat (12) @(posedge aclk);
        chk(32'(adc_power_en), 32'h0000_0001);
        rd(8'h04, 32'h0000_00FF, 2'b00);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
